/* File: shared/dbc_pkg.sv */
// Constants, field layouts and carrier types of the debug byte channel
package dbc_pkg;

  // Avalon-MM register map (byte addresses, one word each)
  localparam int         ADDR_W          = 8;
  localparam logic [7:0] OFS_CHAN        = 8'h00;
  localparam logic [7:0] OFS_MCU_STATUS  = 8'h04;
  localparam logic [7:0] OFS_CFG_STATUS  = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h10;
  localparam logic [7:0] OFS_PLAIN_IO    = 8'h14;

  // Channel register fields
  localparam int CHAN_DIRTY_BIT = 7;

  // mcu_status_register fields
  localparam int MCU_TAP_DISABLE_BIT = 0;

  // Config status fields
  localparam int CFG_DBG_FUSE_BIT   = 0;
  localparam int CFG_TAP_FUSE_BIT   = 1;
  localparam int CFG_LOCK1_BIT      = 2;
  localparam int CFG_LOCK2_BIT      = 3;
  localparam int CFG_ACCESS_BIT     = 4;
  localparam int CFG_GATE_BIT       = 5;
  localparam int CFG_TAP_ACTIVE_BIT = 6;

  // Interrupt status / mask fields
  localparam int IRQ_W           = 3;
  localparam int IRQ_COLLECT_BIT = 0;
  localparam int IRQ_OVERRUN_BIT = 1;
  localparam int IRQ_REFUSED_BIT = 2;

  // Fuse and lock byte fields (1 = programmed)
  localparam int FUSE_DBG_BIT  = 0;
  localparam int FUSE_TAP_BIT  = 1;
  localparam int LOCK_ONE_BIT  = 0;
  localparam int LOCK_TWO_BIT  = 1;

  // Reset values
  localparam logic [7:0] RST_CHAN  = 8'h00;
  localparam logic [1:0] RST_FUSE  = 2'h2;
  localparam logic [1:0] RST_LOCK  = 2'h0;
  localparam logic [7:0] RST_PLAIN = 8'h00;

  // Test access port instruction register
  localparam int         IR_W           = 4;
  localparam logic [3:0] IR_PROG_WRITE  = 4'h4;
  localparam logic [3:0] IR_PROG_READ   = 4'h5;
  localparam logic [3:0] IR_CHIP_ERASE  = 4'h6;
  localparam logic [3:0] IR_PRIV_READ   = 4'h8;
  localparam logic [3:0] IR_PRIV_CLEAR  = 4'h9;
  localparam logic [3:0] IR_PRIV_ACCESS = 4'ha;
  localparam logic [3:0] IR_BYPASS      = 4'hf;
  localparam logic [3:0] IR_CAPTURE     = 4'h1;

  // Programming data register layout
  localparam int DR_W      = 24;
  localparam int NVM_AW    = 14;
  localparam int SYNC_W    = 3;

  // Nonvolatile spaces
  localparam logic [1:0] SPACE_FLASH  = 2'h0;
  localparam logic [1:0] SPACE_EEPROM = 2'h1;
  localparam logic [1:0] SPACE_FUSE   = 2'h2;
  localparam logic [1:0] SPACE_LOCK   = 2'h3;

  // Request towards the nonvolatile arrays
  typedef struct packed {
    logic              we;
    logic              erase;
    logic [1:0]        space;
    logic [NVM_AW-1:0] addr;
    logic [7:0]        wdata;
  } dbc_nvm_t;

  // Test access port state levels
  typedef struct packed {
    logic cap_dr;
    logic sh_dr;
    logic upd_dr;
    logic sh_ir;
  } dbc_tap_lvl_t;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
    ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
    ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } dbc_tap_st_t;

endpackage

/* File: hw/dbc_sync.sv */
// Two-flop synchronisers for the pin inputs
`timescale 1ns/100ps
module dbc_sync
  import dbc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [SYNC_W-1:0] pin_in,
  output logic      [SYNC_W-1:0] pin_sync
);

  logic [SYNC_W-1:0] meta_reg;

  // First stage feeds only the second stage
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_sync
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          meta_reg[g] <= 1'b0;
          pin_sync[g] <= 1'b0;
        end else begin
          meta_reg[g] <= pin_in[g];
          pin_sync[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

endmodule // dbc_sync

/* File: hw/dbc_tap.sv */
// Test access port controller and instruction register
`timescale 1ns/100ps
module dbc_tap
  import dbc_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire logic            tap_en,
  input  wire logic            tck_rise,
  input  wire logic            tms_s,
  input  wire logic            tdi_s,
  output dbc_tap_lvl_t         lvl,
  output logic      [IR_W-1:0] ir_reg,
  output logic                 ir_lsb
);

  dbc_tap_st_t     st_reg;
  dbc_tap_st_t     st_next;
  logic [IR_W-1:0] ir_sh_reg;

  // Standard sixteen-state walk on tms
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_RESET:  st_next = tms_s ? ST_RESET : ST_IDLE;
      ST_IDLE:   st_next = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: st_next = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: st_next = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  st_next = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: st_next = tms_s ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: st_next = tms_s ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: st_next = tms_s ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: st_next = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: st_next = tms_s ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: st_next = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  st_next = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: st_next = tms_s ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: st_next = tms_s ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: st_next = tms_s ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: st_next = tms_s ? ST_SEL_DR : ST_IDLE;
      default:   st_next = ST_RESET;
    endcase
  end

  // Held in reset while the port is disabled
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= ST_RESET;
    end else if (!tap_en) begin
      st_reg <= ST_RESET;
    end else if (tck_rise) begin
      st_reg <= st_next;
    end
  end

  // Instruction shift and update
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ir_sh_reg <= IR_BYPASS;
      ir_reg    <= IR_BYPASS;
    end else if (!tap_en || st_reg == ST_RESET) begin
      ir_sh_reg <= IR_BYPASS;
      ir_reg    <= IR_BYPASS;
    end else if (tck_rise) begin
      if (st_reg == ST_CAP_IR) begin
        ir_sh_reg <= IR_CAPTURE;
      end else if (st_reg == ST_SH_IR) begin
        ir_sh_reg <= {tdi_s, ir_sh_reg[IR_W-1:1]};
      end else if (st_reg == ST_UPD_IR) begin
        ir_reg <= ir_sh_reg;
      end
    end
  end

  assign ir_lsb     = ir_sh_reg[0];
  assign lvl.cap_dr = (st_reg == ST_CAP_DR);
  assign lvl.sh_dr  = (st_reg == ST_SH_DR);
  assign lvl.upd_dr = (st_reg == ST_UPD_DR);
  assign lvl.sh_ir  = (st_reg == ST_SH_IR);

endmodule // dbc_tap

/* File: hw/dbc_top.sv */
// CPU-to-debugger byte channel with test access port and fuse gating
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
module dbc_top
  import dbc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  output logic                   irq,
  // Four-pin test port
  input  wire logic              tck,
  input  wire logic              tms,
  input  wire logic              tdi,
  output logic                   tdo,
  output logic                   tdo_oe,
  // Nonvolatile arrays
  output dbc_nvm_t               nvm,
  input  wire logic [7:0]        nvm_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [SYNC_W-1:0] pin_sync;
  logic              tck_s;
  logic              tms_s;
  logic              tdi_s;
  logic              tck_prev_reg;
  logic              tck_rise;
  logic              tck_fall;
  dbc_tap_lvl_t      lvl;
  logic [IR_W-1:0]   ir;
  logic              ir_lsb;
  logic [DR_W-1:0]   dr_reg;
  logic              bypass_reg;
  logic              cap_dr;
  logic              upd_dr;
  logic              sh_dr;
  logic [7:0]        chan_reg;
  logic              dirty_reg;
  logic [7:0]        plain_reg;
  logic              tap_dis_reg;
  logic [1:0]        fuse_reg;
  logic [1:0]        lock_reg;
  logic              access_reg;
  logic [IRQ_W-1:0]  irq_stat_reg;
  logic [IRQ_W-1:0]  irq_mask_reg;
  logic [IRQ_W-1:0]  irq_event;
  logic              tap_en;
  logic              locked;
  logic              dbg_ok;
  logic              gate_open;
  logic              bus_req;
  logic              bus_do;
  logic              wr_lo;
  logic              cpu_chan_wr;
  logic              dbg_clear;
  logic              fuse_refused;
  logic [7:0]        fuse_wr;
  logic [31:0]       rdata_next;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and clock edge detection

  dbc_sync u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .pin_in   ({tck, tms, tdi}),
    .pin_sync (pin_sync)
  );

  assign tck_s = pin_sync[2];
  assign tms_s = pin_sync[1];
  assign tdi_s = pin_sync[0];

  // Edges seen only after two stages of sync
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tck_prev_reg <= 1'b0;
    end else begin
      tck_prev_reg <= tck_s;
    end
  end

  assign tck_rise = tck_s & ~tck_prev_reg;
  assign tck_fall = ~tck_s & tck_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Security gating

  // Port runs only with its fuse and the disable bit clear
  assign tap_en    = fuse_reg[FUSE_TAP_BIT] & ~tap_dis_reg;
  assign locked    = |lock_reg;
  // No debug back door once any lock is set
  assign dbg_ok    = fuse_reg[FUSE_DBG_BIT] & ~locked;
  // Shared address goes to the channel only when both agree
  assign gate_open = dbg_ok & access_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Test access port

  dbc_tap u_tap (
    .clk      (clk),
    .rst_b    (rst_b),
    .tap_en   (tap_en),
    .tck_rise (tck_rise),
    .tms_s    (tms_s),
    .tdi_s    (tdi_s),
    .lvl      (lvl),
    .ir_reg   (ir),
    .ir_lsb   (ir_lsb)
  );

  // Actions happen on the tck edge that leaves each state
  assign cap_dr = tck_rise & lvl.cap_dr;
  assign sh_dr  = tck_rise & lvl.sh_dr;
  assign upd_dr = tck_rise & lvl.upd_dr;

  // Private instructions act only while debug is permitted
  assign dbg_clear = upd_dr & dbg_ok & (ir == IR_PRIV_CLEAR);

  // Fuse byte as written, debug fuse refused while locked
  always_comb begin
    fuse_wr      = dr_reg[7:0];
    fuse_refused = 1'b0;
    if (locked && fuse_wr[FUSE_DBG_BIT] && !fuse_reg[FUSE_DBG_BIT]) begin
      fuse_wr[FUSE_DBG_BIT] = 1'b0;
      fuse_refused          = upd_dr & (ir == IR_PROG_WRITE) &
                              (dr_reg[23:22] == SPACE_FUSE);
    end
  end

  // Data register: capture, shift lsb first, tdi into msb
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dr_reg <= '0;
    end else if (cap_dr) begin
      if (ir == IR_PRIV_READ && dbg_ok) begin
        dr_reg <= {15'h0000, dirty_reg, chan_reg};
      end else if (ir == IR_PROG_READ) begin
        case (nvm.space)
          SPACE_FUSE:  dr_reg <= {nvm.space, nvm.addr, 6'h00, fuse_reg};
          SPACE_LOCK:  dr_reg <= {nvm.space, nvm.addr, 6'h00, lock_reg};
          // Verify read-out blocked by the second lock
          default:     dr_reg <= {nvm.space, nvm.addr,
                                  lock_reg[LOCK_TWO_BIT] ? 8'h00 : nvm_rdata};
        endcase
      end else begin
        dr_reg <= dr_reg;
      end
    end else if (sh_dr) begin
      dr_reg <= {tdi_s, dr_reg[DR_W-1:1]};
    end
  end

  // Bypass bit for every other instruction
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bypass_reg <= 1'b0;
    end else if (cap_dr) begin
      bypass_reg <= 1'b0;
    end else if (sh_dr) begin
      bypass_reg <= tdi_s;
    end
  end

  // Output changes on falling tck so the debugger samples it stable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (!tap_en) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe <= lvl.sh_dr | lvl.sh_ir;
      if (lvl.sh_ir) begin
        tdo <= ir_lsb;
      end else if (ir == IR_PROG_WRITE || ir == IR_PROG_READ ||
                   (dbg_ok && (ir == IR_PRIV_READ || ir == IR_PRIV_ACCESS))) begin
        tdo <= dr_reg[0];
      end else begin
        tdo <= bypass_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Programming of nonvolatile content

  // Fuses and locks; locks only become set, erase clears them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fuse_reg <= RST_FUSE;
      lock_reg <= RST_LOCK;
    end else if (upd_dr && ir == IR_CHIP_ERASE) begin
      lock_reg <= RST_LOCK;
    end else if (upd_dr && ir == IR_PROG_WRITE) begin
      if (dr_reg[23:22] == SPACE_FUSE) begin
        fuse_reg <= fuse_wr[1:0];
      end else if (dr_reg[23:22] == SPACE_LOCK) begin
        lock_reg <= lock_reg | dr_reg[1:0];
      end
    end
  end

  // Array request: one-cycle strobes, address held for verify
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nvm <= '0;
    end else begin
      nvm.we    <= 1'b0;
      nvm.erase <= 1'b0;
      if (upd_dr && ir == IR_CHIP_ERASE) begin
        nvm.erase <= 1'b1;
      end else if (upd_dr && (ir == IR_PROG_WRITE || ir == IR_PROG_READ)) begin
        nvm.space <= dr_reg[23:22];
        nvm.addr  <= dr_reg[21:8];
        nvm.wdata <= dr_reg[7:0];
        // First lock stops further array writes
        nvm.we    <= (ir == IR_PROG_WRITE) & ~dr_reg[23] &
                     ~lock_reg[LOCK_ONE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave

  assign bus_req = avs_read | avs_write;
  // Access completes on the edge that sees waitrequest low
  assign bus_do  = bus_req & ~avs_waitrequest;
  assign wr_lo   = avs_write & bus_do & avs_byteenable[0];
  assign cpu_chan_wr = wr_lo & (avs_address == OFS_CHAN) & gate_open;

  // One wait cycle per access
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
    end
  end

  // Read mux, unmapped addresses read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (avs_address == OFS_CHAN) begin
      if (gate_open) begin
        rdata_next[7:0] = {dirty_reg, chan_reg[6:0]};
      end else begin
        rdata_next[7:0] = plain_reg;
      end
    end else if (avs_address == OFS_MCU_STATUS) begin
      rdata_next[MCU_TAP_DISABLE_BIT] = tap_dis_reg;
    end else if (avs_address == OFS_CFG_STATUS) begin
      rdata_next[CFG_DBG_FUSE_BIT]   = fuse_reg[FUSE_DBG_BIT];
      rdata_next[CFG_TAP_FUSE_BIT]   = fuse_reg[FUSE_TAP_BIT];
      rdata_next[CFG_LOCK1_BIT]      = lock_reg[LOCK_ONE_BIT];
      rdata_next[CFG_LOCK2_BIT]      = lock_reg[LOCK_TWO_BIT];
      rdata_next[CFG_ACCESS_BIT]     = access_reg;
      rdata_next[CFG_GATE_BIT]       = gate_open;
      rdata_next[CFG_TAP_ACTIVE_BIT] = tap_en;
    end else if (avs_address == OFS_IRQ_STATUS) begin
      rdata_next[IRQ_W-1:0] = irq_stat_reg;
    end else if (avs_address == OFS_IRQ_MASK) begin
      rdata_next[IRQ_W-1:0] = irq_mask_reg;
    end else if (avs_address == OFS_PLAIN_IO) begin
      rdata_next[7:0] = plain_reg;
    end
  end

  // Read data loaded while waitrequest is high, held through the answer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel register and dirty flag

  // Byte held for the debugger
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_reg <= RST_CHAN;
    end else if (cpu_chan_wr) begin
      chan_reg <= avs_writedata[7:0];
    end
  end

  // A CPU write in the clearing cycle wins over the clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dirty_reg <= 1'b0;
    end else if (cpu_chan_wr) begin
      dirty_reg <= 1'b1;
    end else if (dbg_clear) begin
      dirty_reg <= 1'b0;
    end
  end

  // Ordinary location behind the shared address
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      plain_reg <= RST_PLAIN;
    end else if (wr_lo && ((avs_address == OFS_CHAN && !gate_open) ||
                           avs_address == OFS_PLAIN_IO)) begin
      plain_reg <= avs_writedata[7:0];
    end
  end

  // Debugger grant, dropped whenever debug is no longer permitted
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      access_reg <= 1'b0;
    end else if (!dbg_ok) begin
      access_reg <= 1'b0;
    end else if (upd_dr && ir == IR_PRIV_ACCESS) begin
      access_reg <= dr_reg[0];
    end
  end

  // Port disable bit in the mcu status register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tap_dis_reg <= 1'b0;
    end else if (wr_lo && avs_address == OFS_MCU_STATUS) begin
      tap_dis_reg <= avs_writedata[MCU_TAP_DISABLE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  assign irq_event[IRQ_COLLECT_BIT] = dbg_clear & dirty_reg;
  assign irq_event[IRQ_OVERRUN_BIT] = cpu_chan_wr & dirty_reg;
  assign irq_event[IRQ_REFUSED_BIT] = fuse_refused;

  // Sticky bits, write one to clear, new event wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_reg <= '0;
    end else if (wr_lo && avs_address == OFS_IRQ_STATUS) begin
      irq_stat_reg <= (irq_stat_reg & ~avs_writedata[IRQ_W-1:0]) | irq_event;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_event;
    end
  end

  // Mask, one enables the source
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask_reg <= '0;
    end else if (wr_lo && avs_address == OFS_IRQ_MASK) begin
      irq_mask_reg <= avs_writedata[IRQ_W-1:0];
    end
  end

  // Registered level output, one cycle behind the status
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

endmodule // dbc_top

/* File: test/dbc_properties.sv */
// Port timing checker for the debug byte channel
`timescale 1ns/100ps
module dbc_properties
  import dbc_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              irq,
  input wire logic              tdo_oe,
  input wire dbc_nvm_t          nvm
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic rd_go;
  logic cfg_go;
  ////////////////////////////////////////
  // Read accepted now, data shows next cycle
  assign rd_go  = avs_read && avs_waitrequest;
  assign cfg_go = rd_go && avs_address == OFS_CFG_STATUS;
  wait_one_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("late answer");
  wait_pulse_a: assert property (
    !avs_waitrequest |=> avs_waitrequest) else $error("answer held too long");
  idle_wait_a: assert property (
    !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest) else $error("spurious answer");
  read_hold_a: assert property (
    !rd_go |=> $stable(avs_readdata)) else $error("read data moved");
  upper_zero_a: assert property (
    avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
  // Gate needs fuse and access, and no lock at all
  gate_logic_a: assert property (
    cfg_go |=> avs_readdata[CFG_GATE_BIT] == (avs_readdata[CFG_DBG_FUSE_BIT]
      && avs_readdata[CFG_ACCESS_BIT] && !avs_readdata[CFG_LOCK1_BIT]
      && !avs_readdata[CFG_LOCK2_BIT])) else $error("gate wrong");
  tap_gate_a: assert property (
    cfg_go |=> !avs_readdata[CFG_TAP_ACTIVE_BIT] || avs_readdata[CFG_TAP_FUSE_BIT])
    else $error("port active without fuse");
  reset_quiet_a: assert property (
    !$past(rst_b) |-> avs_waitrequest && !irq && !tdo_oe) else $error("not quiet after reset");
  nvm_pulse_a: assert property (
    nvm.we || nvm.erase |=> !nvm.we && !nvm.erase) else $error("array strobe too long");
endmodule // dbc_properties
bind dbc_top dbc_properties dbc_properties_inst (.clk(clk), .rst_b(rst_b),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
  .tdo_oe(tdo_oe), .nvm(nvm));

/* File: test/dbc_debugger.sv */
// Behavioural debugger driving the four-pin test port
`timescale 1ns/100ps
module dbc_debugger
  import dbc_pkg::*;
(
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  ////////////////////////////////////////
  // Clock stands low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One 64 ns clock; data out taken late in the high phase, well after it settles
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #32 tck = 1'b1;
    #31 q = tdo;
    #1 tck = 1'b0;
  endtask
  // Five ones reach reset whatever the state, then park in idle
  task automatic park();
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
  // Idle to idle scan, lsb first, using only the four pins
  task automatic scan(input logic ir, input int n, input logic [DR_W-1:0] din,
                      output logic [DR_W-1:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
  // Instruction followed by one data scan
  task automatic cmd(input logic [IR_W-1:0] op, input logic [DR_W-1:0] dr,
                     output logic [DR_W-1:0] dout);
    logic [DR_W-1:0] d;
    scan(1'b1, IR_W, {20'h0, op}, d);
    scan(1'b0, DR_W, dr, dout);
  endtask
  // Fetch the byte, then clear the flag so the next write counts as new
  task automatic collect(output logic [8:0] got);
    logic [DR_W-1:0] d;
    cmd(IR_PRIV_READ, '0, d);
    got = d[8:0];
    cmd(IR_PRIV_CLEAR, '0, d);
  endtask
endmodule // dbc_debugger

/* File: test/tb.sv */
// Self-checking bench for the debug byte channel
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: %h %h", $time, g, e); end end
module tb
  import dbc_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        tdo;
  logic        tdo_oe;
  logic        tdo_line;
  dbc_nvm_t    nvm;
  logic [7:0]  nvm_rdata = 8'h00;
  logic [31:0] exp_w;
  logic [31:0] seed = 32'd89359;
  logic [7:0]  expq[$];
  logic [7:0]  b;
  logic [7:0]  p;
  logic [8:0]  got;
  logic [23:0] dd;
  int          failures = 0;
  int          samples_checked = 0;
  ////////////////////////////////////////
  always #4 clk = ~clk;
  // Released pin floats to its pull-up level
  assign tdo_line = tdo_oe ? tdo : 1'b1;
  dbc_top dbc_top_inst (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .nvm(nvm), .nvm_rdata(nvm_rdata));
  dbc_debugger dbc_debugger_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Bus cycle held until waitrequest is seen low; reads leave a note
  task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] be = 4'hf);
    @(posedge clk);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    if (rd) expq.push_back(d);
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Each finished read against the oldest note
  // Note taken off once, so a mismatch cannot skip the next one
  always @(posedge clk) if (avs_read && avs_waitrequest === 1'b0) begin
    exp_w = {24'h0, expq.pop_front()};
    `CHK(avs_readdata, exp_w)
  end
  // Hang guard, far beyond the some 26 scans of the run
  initial begin
    #400000;
    failures++;
    results();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    dbc_debugger_inst.park();
    bus(1, OFS_CHAN, 8'h00);
    bus(1, OFS_CFG_STATUS, 8'h42);
    seed = xs(seed);
    p = seed[7:0];
    bus(0, OFS_PLAIN_IO, p);
    bus(0, OFS_CHAN, ~p, 4'h0);
    bus(1, OFS_CHAN, p);
    dbc_debugger_inst.cmd(IR_PROG_WRITE, {SPACE_FUSE, 14'h0, 8'h03}, dd);
    dbc_debugger_inst.cmd(IR_PRIV_ACCESS, 24'h1, dd);
    bus(1, OFS_CFG_STATUS, 8'h73);
    bus(1, OFS_CHAN, 8'h00);
    dbc_debugger_inst.cmd(IR_PROG_WRITE, {SPACE_FLASH, 14'h12, 8'h5a}, dd);
    `CHK({nvm.space, nvm.addr, nvm.wdata}, {SPACE_FLASH, 14'h12, 8'h5a})
    // Verify read of the array word just addressed
    @(posedge clk);
    nvm_rdata <= ~p;
    dbc_debugger_inst.cmd(IR_PROG_READ, {SPACE_FLASH, 14'h12, 8'h00}, dd);
    `CHK(dd, {SPACE_FLASH, 14'h12, ~p})
    // Back-to-back writes, second and third while still dirty
    bus(0, OFS_IRQ_MASK, 8'h07);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      b = seed[7:0];
      bus(0, OFS_CHAN, b);
      bus(1, OFS_CHAN, {1'b1, b[6:0]});
    end
    bus(1, OFS_PLAIN_IO, p);
    dbc_debugger_inst.collect(got);
    `CHK(got, {1'b1, b})
    bus(1, OFS_CHAN, {1'b0, b[6:0]});
    bus(1, OFS_IRQ_STATUS, 8'h03);
    `CHK(irq, 1'b1)
    bus(0, OFS_IRQ_MASK, 8'h04);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    bus(0, OFS_IRQ_STATUS, 8'h03);
    bus(1, OFS_IRQ_STATUS, 8'h00);
    // Any lock closes the gate; a locked part refuses the debug fuse
    dbc_debugger_inst.cmd(IR_PROG_WRITE, {SPACE_LOCK, 14'h0, 8'h01}, dd);
    bus(1, OFS_CFG_STATUS, 8'h47);
    bus(1, OFS_CHAN, p);
    dbc_debugger_inst.cmd(IR_CHIP_ERASE, '0, dd);
    dbc_debugger_inst.cmd(IR_PROG_WRITE, {SPACE_FUSE, 14'h0, 8'h02}, dd);
    dbc_debugger_inst.cmd(IR_PROG_WRITE, {SPACE_LOCK, 14'h0, 8'h02}, dd);
    dbc_debugger_inst.cmd(IR_PROG_WRITE, {SPACE_FUSE, 14'h0, 8'h03}, dd);
    bus(1, OFS_CFG_STATUS, 8'h4a);
    bus(1, OFS_IRQ_STATUS, 8'h04);
    `CHK(irq, 1'b1)
    dbc_debugger_inst.cmd(IR_CHIP_ERASE, '0, dd);
    dbc_debugger_inst.cmd(IR_PROG_WRITE, {SPACE_FUSE, 14'h0, 8'h03}, dd);
    bus(1, OFS_CFG_STATUS, 8'h43);
    // Disable bit shuts the port
    bus(0, OFS_MCU_STATUS, 8'h01);
    bus(1, OFS_MCU_STATUS, 8'h01);
    bus(1, OFS_CFG_STATUS, 8'h03);
    bus(1, 8'h40, 8'h00);
    repeat (4) @(posedge clk);
    results();
  end
endmodule // tb
